// [logic/slhd_params.svh]
// constants and behaviour notes for the serial led head driver
// Notes on behaviour
// (RULE1) shift serial bit into 32 stages on clock rise
// (RULE2) latch follows register while gate low, freezes high
// (RULE3) driver on only when bit 1, enable 1, inhibit 0
// (RULE4) lamp check, with enable 1 and inhibit 0, sets latch, turns every driver on
// (RULE5) thirty-two open-drain outputs, one per latch bit
// (RULE6) controller keeps shift clock at most 5 MHz
// (RULE7) controller waits 100 ns before asserting hold gate
// (RULE8) shifting may resume 0 ns after gate release
// (RULE9) controller ties unused lamp check low
// (RULE10) serial output shows last stage for chaining
// (RULE11) register and latch are not reset
`ifndef SLHD_PARAMS_SVH
`define SLHD_PARAMS_SVH
`define SLHD_CHANNELS 32
`define SLHD_CLK_PERIOD_PS 4000
`define SLHD_SYNC_STAGES 3
`define SLHD_SHIFT_MAX_FREQ_KHZ 5000
`define SLHD_GATE_WAIT_NS 100
`define SLHD_RESUME_WAIT_NS 0
`endif

// [logic/slhd_pkg.sv]
// types shared by the serial led head driver
package slhd_pkg;
  typedef logic [2:0] slhd_sync_t;
endpackage

// [logic/slhd_sync.sv]
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`include "slhd_params.svh"
module slhd_sync
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic async_in,
  output logic level_out
);
  import slhd_pkg::*;
  slhd_sync_t sync_r;
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sync_r <= '0;
    else
      sync_r <= {sync_r[1:0], async_in};
  end
  // only stages two and three are compared; stage one is metastable
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      level_out <= 1'b0;
    else if (sync_r[1] == sync_r[2])
      level_out <= sync_r[2];
  end
endmodule // slhd_sync

// [logic/slhd_top.sv]
// serial led head driver: shift register, hold latch, output gating
`timescale 1ns/1ps
`include "slhd_params.svh"
module slhd_top
#(
  parameter int CHANNELS = `SLHD_CHANNELS
)
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic shift_clk_in,
  input wire logic serial_data_in,
  input wire logic hold_gate_in,
  input wire logic bank_output_enable_in,
  input wire logic inhibit_in,
  input wire logic lamp_check_in,
  output logic serial_data_out,
  output logic [CHANNELS-1:0] driver_outputs_out,
  output logic [CHANNELS-1:0] driver_outputs_oe_out
);
  import slhd_pkg::*;

  initial
  begin
    if (CHANNELS < 2)
      $error("slhd_top: CHANNELS must be at least 2");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic clk_s;
  logic din_s;
  logic gate_s;
  logic en_s;
  logic inh_s;
  logic chk_s;
  logic clk_d_r;

  slhd_sync u_clk (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .async_in(shift_clk_in), .level_out(clk_s));
  slhd_sync u_din (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .async_in(serial_data_in), .level_out(din_s));
  slhd_sync u_gate (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .async_in(hold_gate_in), .level_out(gate_s));
  slhd_sync u_en (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .async_in(bank_output_enable_in), .level_out(en_s));
  slhd_sync u_inh (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .async_in(inhibit_in), .level_out(inh_s));
  slhd_sync u_chk (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .async_in(lamp_check_in), .level_out(chk_s));

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      clk_d_r <= 1'b0;
    else
      clk_d_r <= clk_s;
  end

  logic shift_rise;
  assign shift_rise = clk_s & ~clk_d_r;

  // ----------------------------------------
  // shift register and latch
  // ----------------------------------------
  // no reset: contents stay undefined until loaded, as on the part
  logic [CHANNELS-1:0] shift_r;
  logic [CHANNELS-1:0] latch_r;
  logic lamp_all;

  always_ff @(posedge core_clk_in)
  begin
    if (shift_rise)
      shift_r <= {shift_r[CHANNELS-2:0], din_s}; // RULE1 RULE11
  end

  // data sampled with the clock edge, so setup is met by the pin delay
  assign serial_data_out = shift_r[CHANNELS-1]; // RULE10

  assign lamp_all = chk_s & ~inh_s & en_s;

  always_ff @(posedge core_clk_in)
  begin
    if (lamp_all)
      latch_r <= '1; // RULE4
    else if (!gate_s)
      latch_r <= shift_r; // RULE2 RULE11
  end

  // ----------------------------------------
  // open-drain drivers
  // ----------------------------------------
  logic [CHANNELS-1:0] on_r;
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      on_r <= '0;
    else
      on_r <= latch_r & {CHANNELS{en_s & ~inh_s}}; // RULE3
  end

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_drv
      assign driver_outputs_out[gi] = 1'b0; // RULE5
      assign driver_outputs_oe_out[gi] = on_r[gi]; // RULE5
    end
  endgenerate
endmodule // slhd_top

// [tb/slhd_ctrl_model.sv]
// controller model: shifts words in and strobes the hold gate
`timescale 1ns/1ps
module slhd_ctrl_model
(
  output logic sclk_out,
  output logic sdata_out,
  output logic gate_out
);
  initial
  begin
    sclk_out = 0;
    sdata_out = 0;
    gate_out = 1;
  end
  task automatic load(input logic [31:0] w, input bit strobe);
    for (int i = 31; i >= 0; i--)
    begin
      sdata_out = w[i];
      #100 sclk_out = 1;
      #100 sclk_out = 0;
    end
    // released data line does not keep its value
    sdata_out = ~sdata_out;
    #100 gate_out = !strobe;
    #100 gate_out = 1;
  endtask
endmodule // slhd_ctrl_model

// [tb/slhd_top_sva.sv]
// assertions for the serial led head driver
`timescale 1ns/1ps
module slhd_top_sva
#(
  parameter int CHANNELS = 32
)
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic bank_output_enable_in,
  input wire logic inhibit_in,
  input wire logic lamp_check_in,
  input wire logic [CHANNELS-1:0] driver_outputs_out,
  input wire logic [CHANNELS-1:0] driver_outputs_oe_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // pin to driver takes five edges: three sync stages, filter, driver flop
  property p_inh; inhibit_in [*6] |-> driver_outputs_oe_out == '0; endproperty
  a_inh: assert property (p_inh) else $error("driver on while inhibited");
  property p_en; !bank_output_enable_in [*6] |-> driver_outputs_oe_out == '0; endproperty
  a_en: assert property (p_en) else $error("driver on while bank off");
  property p_lamp;
    (lamp_check_in && bank_output_enable_in && !inhibit_in) [*8] |-> &driver_outputs_oe_out;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp check left a driver off");
  property p_lamp_inh;
    (lamp_check_in && inhibit_in) [*6] |-> driver_outputs_oe_out == '0;
  endproperty
  a_lamp_inh: assert property (p_lamp_inh) else $error("lamp check beat inhibit");
  property p_lamp_en;
    (lamp_check_in && !bank_output_enable_in) [*6] |-> driver_outputs_oe_out == '0;
  endproperty
  a_lamp_en: assert property (p_lamp_en) else $error("lamp check beat bank off");
  property p_od; driver_outputs_out == '0; endproperty
  a_od: assert property (p_od) else $error("open drain output driven high");
endmodule // slhd_top_sva
bind slhd_top slhd_top_sva #(.CHANNELS(CHANNELS)) u_sva (.*);

// [tb/tb_slhd_top.sv]
// testbench for the serial led head driver
`timescale 1ns/1ps
module tb_slhd_top;
  logic clk = 0, rstn = 0, en = 1, inh = 0, lamp = 0, sclk, sdat, gate, sout;
  logic [31:0] dq, oe;
  int bad_count = 0, compares = 0;
  always #2 clk = ~clk;
  slhd_ctrl_model ctrl (.sclk_out(sclk), .sdata_out(sdat), .gate_out(gate));
  slhd_top dut (.core_clk_in(clk), .resetn_in(rstn), .shift_clk_in(sclk),
    .serial_data_in(sdat), .hold_gate_in(gate), .bank_output_enable_in(en),
    .inhibit_in(inh), .lamp_check_in(lamp), .serial_data_out(sout),
    .driver_outputs_out(dq), .driver_outputs_oe_out(oe));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task settle; repeat (10) @(negedge clk); endtask
  task t_load;
    ctrl.load(32'ha5c30f81, 1);
    settle;
    chk("oe", 32'ha5c30f81, oe);
    chk("sout", 32'h1, {31'h0, sout});
    chk("dq", 32'h0, dq);
  endtask
  task t_hold; ctrl.load(32'h0, 0); settle; chk("held", 32'ha5c30f81, oe); endtask
  task t_gating;
    inh = 1; settle; chk("inh", 32'h0, oe);
    inh = 0; en = 0; settle; chk("en", 32'h0, oe);
  endtask
  task t_lamp; en = 1; lamp = 1; settle; chk("lamp", '1, oe); lamp = 0; endtask
  task give_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rstn = 1;
    t_load;
    t_hold;
    t_gating;
    t_lamp;
    give_verdict;
  end
endmodule // tb_slhd_top
